/* bench/smic_host.sv */
// host model: drives the register port of one counter channel
// assumes the bench clock; the bench top calls these tasks
`default_nettype none

module smic_host (
  // system
  input  wire logic        clock_i,
  // register port
  output logic      [1:0]  addr_o,
  output logic      [7:0]  wdata_o,
  output logic             wr_o,
  output logic             rd_o,
  input  wire logic [15:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus from time zero
  initial begin
    addr_o  = 2'h0;
    wdata_o = 8'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one write cycle, released at the edge that takes it
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clock_i);
    wr_o    <= 1'b0;
    wdata_o <= ~d;  // no stale data once released
    #1;
  endtask

  // one read cycle; data stand only in the following cycle
  task automatic rd_reg(input logic [1:0] a, output logic [15:0] d);
    @(posedge clock_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clock_i);
    rd_o   <= 1'b0;
    #1;
    d = rdata_i;
  endtask

  // control word, then count low byte, then high byte if two-byte
  task automatic prog(input logic [2:0] m, input logic bcd, input logic two,
                      input logic [15:0] n);
    logic [15:0] c;
    c = n;
    if ((m == 3'h2 || m == 3'h3) && c == 16'h0001) begin
      c = 16'h0002;  // smallest legal periodic count
    end
    wr_reg(smic_pkg::SMIC_ADDR_CTRL, {3'h0, two, m, bcd});
    wr_reg(smic_pkg::SMIC_ADDR_COUNT, c[7:0]);
    if (two) begin
      wr_reg(smic_pkg::SMIC_ADDR_COUNT, c[15:8]);
    end
  endtask
endmodule

`default_nettype wire

/* bench/testbench.sv */
// self-checking bench for one six-mode counter channel
// assumes smic_pkg, smic_counter and smic_host are compiled first
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // design pins
  logic        clock_i;
  logic        sys_rst_i;
  logic        cnt_clk_i;
  logic        gate_i;
  logic        out_o;
  logic [1:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  // bookkeeping
  int          errors = 0;
  int          n_compared = 0;
  int          seed;
  int          n;
  int          m;
  int          lows;
  logic [15:0] rv;

  smic_host host_u (.clock_i(clock_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
                    .rd_o(rd), .rdata_i(rdata));
  smic_counter dut_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .addr_i(addr),
                      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
                      .cnt_clk_i(cnt_clk_i), .gate_i(gate_i), .out_o(out_o));

  // 100 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare tasks and verdict
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // counter pin drivers: pulse is 2 cycles high, 2 low, output settled after
  task automatic pulse(input int k);
    repeat (k) begin
      @(posedge clock_i);
      cnt_clk_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      cnt_clk_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      #1;
    end
  endtask

  task automatic set_gate(input logic v);
    @(posedge clock_i);
    gate_i <= v;
  endtask

  // one-cycle-wide rising edge, then gate left at hold
  task automatic trig(input logic hold);
    set_gate(1'b0);
    set_gate(1'b1);
    set_gate(hold);
  endtask

  // expectations
  function automatic logic exp_rate(int k, int n1, int n2);
    return !(k == n1 || k == n1 + n2);
  endfunction

  function automatic logic exp_strobe(int k, int nn);
    return k != nn + 1;
  endfunction

  function automatic int exp_lows(int nn);
    return 2 * (nn / 2);  // low pulses in two whole periods
  endfunction

  // watchdog, well past the planned run
  initial begin
    repeat (90000) @(posedge clock_i);
    errors++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed      = 32'h610f;
    sys_rst_i = 1'b1;
    cnt_clk_i = 1'b0;
    gate_i    = 1'b1;
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    #1;
    host_u.rd_reg(smic_pkg::SMIC_ADDR_STATUS, rv);
    chk_word(rv & 16'hFFBF, 16'h0080);
    // mode 0 terminal count
    repeat (2) begin
      n = 1 + ($unsigned($random(seed)) % 6);
      host_u.prog(3'h0, 1'b0, 1'b0, 16'(n));
      chk_bit(out_o, 1'b0);
      pulse(n);
      chk_bit(out_o, 1'b0);
      pulse(1);
      chk_bit(out_o, 1'b1);
      pulse(2);
      chk_bit(out_o, 1'b1);
    end
    set_gate(1'b0);
    host_u.prog(3'h0, 1'b0, 1'b0, 16'h0003);
    pulse(4);
    chk_bit(out_o, 1'b0);
    set_gate(1'b1);
    pulse(2);
    chk_bit(out_o, 1'b0);
    pulse(1);
    chk_bit(out_o, 1'b1);
    host_u.prog(3'h0, 1'b0, 1'b1, 16'h0002);
    pulse(3);
    host_u.wr_reg(smic_pkg::SMIC_ADDR_COUNT, 8'h04);
    chk_bit(out_o, 1'b0);
    pulse(3);
    host_u.wr_reg(smic_pkg::SMIC_ADDR_COUNT, 8'h00);
    pulse(4);
    chk_bit(out_o, 1'b0);
    pulse(1);
    chk_bit(out_o, 1'b1);
    $display("test mode 0 done");
    // mode 1 one-shot with retrigger and new count
    n = 2 + ($unsigned($random(seed)) % 4);
    host_u.prog(3'h1, 1'b0, 1'b0, 16'(n));
    pulse(2);
    chk_bit(out_o, 1'b1);
    trig(1'b1);
    pulse(2);
    chk_bit(out_o, 1'b0);
    host_u.wr_reg(smic_pkg::SMIC_ADDR_COUNT, 8'(n + 2));
    trig(1'b1);
    for (int k = 1; k <= n + 3; k++) begin
      pulse(1);
      chk_bit(out_o, 1'(k > n + 2));
    end
    $display("test mode 1 done");
    // mode 2 rate with new count, then gate drop in the low pulse
    n = 2 + ($unsigned($random(seed)) % 4);
    m = 2 + ($unsigned($random(seed)) % 4);
    host_u.prog(3'h2, 1'b0, 1'b0, 16'(n));
    chk_bit(out_o, 1'b1);
    pulse(1);
    host_u.wr_reg(smic_pkg::SMIC_ADDR_COUNT, 8'(m));
    for (int k = 2; k <= n + m; k++) begin
      pulse(1);
      chk_bit(out_o, exp_rate(k, n, m));
    end
    set_gate(1'b0);
    repeat (3) @(posedge clock_i);
    #1;
    chk_bit(out_o, 1'b1);
    $display("test mode 2 done");
    // mode 3 square wave, even then odd count
    for (int j = 0; j < 2; j++) begin
      set_gate(1'b1);
      n = 2 * (2 + ($unsigned($random(seed)) % 3)) + j;
      host_u.prog(3'(3 + 4 * j), 1'b0, 1'b0, 16'(n));  // code 7 acts as mode 3
      chk_bit(out_o, 1'b1);
      pulse(1);
      lows = 0;
      repeat (2 * n) begin
        pulse(1);
        lows += int'(out_o === 1'b0);
      end
      chk_word(16'(lows), 16'(exp_lows(n)));
      for (int k = 0; k < n && out_o !== 1'b0; k++) begin
        pulse(1);
      end
      set_gate(1'b0);
      repeat (3) @(posedge clock_i);
      #1;
      chk_bit(out_o, 1'b1);
    end
    $display("test mode 3 done");
    // mode 4 strobe plus register reads
    set_gate(1'b1);
    n = 1 + ($unsigned($random(seed)) % 5);
    m = 1 + ($unsigned($random(seed)) % 5);
    host_u.prog(3'h4, 1'b0, 1'b1, 16'(n));
    host_u.wr_reg(smic_pkg::SMIC_ADDR_STATUS, 8'hFF);
    host_u.rd_reg(smic_pkg::SMIC_ADDR_CTRL, rv);
    chk_word(rv, 16'h0018);
    host_u.rd_reg(smic_pkg::SMIC_ADDR_COUNT, rv);
    chk_word(rv, 16'(n));
    @(posedge clock_i);
    #1;
    chk_word(rdata, 16'h0000);
    for (int k = 1; k <= n + 2; k++) begin
      pulse(1);
      chk_bit(out_o, exp_strobe(k, n));
      if (k == 1) begin
        host_u.wr_reg(smic_pkg::SMIC_ADDR_COUNT, 8'(m + 5));  // first byte only
      end
    end
    host_u.wr_reg(smic_pkg::SMIC_ADDR_COUNT, 8'h00);  // second byte reloads
    for (int k = 1; k <= m + 7; k++) begin
      pulse(1);
      chk_bit(out_o, exp_strobe(k, m + 5));
    end
    $display("test mode 4 done");
    // mode 5 strobe on a short trigger only, new count waits for a retrigger
    n = 1 + ($unsigned($random(seed)) % 5);
    host_u.prog(3'h5, 1'b0, 1'b0, 16'(n));
    pulse(3);
    chk_bit(out_o, 1'b1);
    trig(1'b0);
    for (int k = 1; k <= n + 2; k++) begin
      pulse(1);
      chk_bit(out_o, exp_strobe(k, n));
      if (k == 1) begin
        host_u.wr_reg(smic_pkg::SMIC_ADDR_COUNT, 8'(m + 5));
      end
    end
    trig(1'b0);
    for (int k = 1; k <= m + 7; k++) begin
      pulse(1);
      chk_bit(out_o, exp_strobe(k, m + 5));
    end
    $display("test mode 5 done");
    // decimal maximum count and wrap
    set_gate(1'b1);
    host_u.prog(3'h0, 1'b1, 1'b0, 16'h0000);
    pulse(2);
    host_u.rd_reg(smic_pkg::SMIC_ADDR_ELEM, rv);
    chk_word(rv, 16'h9999);
    pulse(9998);
    chk_bit(out_o, 1'b0);
    pulse(1);
    chk_bit(out_o, 1'b1);
    $display("test maximum count done");
    close_out();
  end
endmodule

`default_nettype wire

/* design/smic_counter.sv */
// one programmable 16-bit down-counter channel with six counting modes
// assumes counter clock and gate are synchronous inputs, slower than clock_i
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`default_nettype none

module smic_counter (
  // system
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  // register port
  input  wire logic [1:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  // counter pins
  input  wire logic        cnt_clk_i,
  input  wire logic        gate_i,
  output logic             out_o
);

  ////////////////////////////////////////////////////////////////////////////
  // edge capture of counter clock and gate

  logic cclk_q,  cclk_d;
  logic gprev_q, gprev_d;
  logic trig_q,  trig_d;
  logic trigs_q, trigs_d;
  logic gates_q, gates_d;
  logic cclk_rise;
  logic cclk_fall;
  logic gate_rise;

  // pulse edges and latched trigger
  always_comb begin
    cclk_rise = cnt_clk_i & ~cclk_q;
    cclk_fall = ~cnt_clk_i & cclk_q;
    gate_rise = gate_i & ~gprev_q;
    cclk_d    = cnt_clk_i;
    gprev_d   = gate_i;
    trig_d    = trig_q;
    trigs_d   = trigs_q;
    gates_d   = gates_q;
    if (cclk_rise) begin
      trigs_d = trig_q;
      gates_d = gate_i;
      trig_d  = 1'b0;                             // cleared once sampled
    end
    if (gate_rise) begin
      trig_d = 1'b1;                              // new edge wins over clear
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cclk_q  <= 1'b0;
      gprev_q <= 1'b1;                            // gate idles high, no false edge after reset
      trig_q  <= 1'b0;
      trigs_q <= 1'b0;
      gates_q <= 1'b0;
    end else begin
      cclk_q  <= cclk_d;
      gprev_q <= gprev_d;
      trig_q  <= trig_d;
      trigs_q <= trigs_d;
      gates_q <= gates_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counting core and register port

  smic_pkg::smic_mode_t mode_q, mode_d;
  logic        bcd_q,   bcd_d;
  logic        two_q,   two_d;
  logic [15:0] cr_q,    cr_d;       // count register
  logic [15:0] ce_q,    ce_d;       // counting element
  logic        out_q,   out_d;
  logic        null_q,  null_d;
  logic        crv_q,   crv_d;      // a count has been written
  logic        lpend_q, lpend_d;    // load on next pulse
  logic        run_q,   run_d;
  logic        lsbw_q,  lsbw_d;     // first byte written, second awaited
  logic        extra_q, extra_d;    // odd square wave, one extra high pulse
  logic [15:0] rdata_q, rdata_d;
  logic [15:0] dec1;
  logic [15:0] dec2;
  logic [15:0] even_cr;
  logic        trig_load;
  logic        wr_ctrl;
  logic        wr_cnt;
  logic        commit;

  always_comb begin
    dec1      = smic_pkg::smic_dec(ce_q, bcd_q);    // wraps to FFFF or 9999
    dec2      = smic_pkg::smic_dec(dec1, bcd_q);
    even_cr   = {cr_q[15:1], 1'b0};                 // odd count loads N-1
    trig_load = cclk_fall & trigs_q & crv_q;
    wr_ctrl   = wr_i & (addr_i == smic_pkg::SMIC_ADDR_CTRL);
    wr_cnt    = wr_i & (addr_i == smic_pkg::SMIC_ADDR_COUNT);
    commit    = wr_cnt & (~two_q | lsbw_q);
    mode_d    = mode_q;
    bcd_d     = bcd_q;
    two_d     = two_q;
    cr_d      = cr_q;
    ce_d      = ce_q;
    out_d     = out_q;
    null_d    = null_q;
    crv_d     = crv_q;
    lpend_d   = lpend_q;
    run_d     = run_q;
    lsbw_d    = lsbw_q;
    extra_d   = extra_q;
    rdata_d   = 16'h0000;

    // counting on the falling edge of the counter clock
    if (cclk_fall) begin
      case (mode_q)
        smic_pkg::SMIC_M_TERMINAL: begin
          if (lpend_q) begin
            ce_d    = cr_q;                         // load, no decrement
            lpend_d = 1'b0;
            run_d   = 1'b1;
            null_d  = 1'b0;
          end else if (run_q && gates_q && !lsbw_q) begin
            ce_d = dec1;                            // gate level enables
            if (ce_q == smic_pkg::SMIC_CNT_ONE) begin
              out_d = 1'b1;                         // reached zero
            end
          end
        end
        smic_pkg::SMIC_M_ONESHOT: begin
          if (trig_load) begin
            ce_d   = cr_q;                          // trigger loads, output low
            out_d  = 1'b0;
            run_d  = 1'b1;
            null_d = 1'b0;
          end else begin
            ce_d = dec1;                            // gate level ignored
            if (run_q && ce_q == smic_pkg::SMIC_CNT_ONE) begin
              out_d = 1'b1;
              run_d = 1'b0;
            end
          end
        end
        smic_pkg::SMIC_M_RATE: begin
          if (lpend_q || trig_load) begin
            ce_d    = cr_q;                         // first load or trigger reload
            lpend_d = 1'b0;
            run_d   = 1'b1;
            out_d   = 1'b1;
            null_d  = 1'b0;
          end else if (run_q && gates_q) begin
            if (ce_q == smic_pkg::SMIC_CNT_ONE) begin
              ce_d   = cr_q;                        // period end picks up new count
              out_d  = 1'b1;
              null_d = 1'b0;
            end else begin
              ce_d = dec1;
              if (ce_q == smic_pkg::SMIC_CNT_TWO) begin
                out_d = 1'b0;                       // low for one pulse at 1
              end
            end
          end
        end
        smic_pkg::SMIC_M_SQUARE: begin
          if (lpend_q || trig_load) begin
            ce_d    = even_cr;
            lpend_d = 1'b0;
            run_d   = 1'b1;
            out_d   = 1'b1;
            extra_d = 1'b0;
            null_d  = 1'b0;
          end else if (run_q && gates_q) begin
            if (extra_q) begin
              out_d   = 1'b0;                       // odd count, late fall
              ce_d    = even_cr;
              extra_d = 1'b0;
              null_d  = 1'b0;
            end else if (ce_q == smic_pkg::SMIC_CNT_TWO) begin
              if (out_q && cr_q[0]) begin
                ce_d    = smic_pkg::SMIC_CNT_ZERO;
                extra_d = 1'b1;
              end else begin
                out_d  = ~out_q;                    // half-cycle end
                ce_d   = even_cr;
                null_d = 1'b0;
              end
            end else begin
              ce_d = dec2;                          // steps by two
            end
          end
        end
        smic_pkg::SMIC_M_SWSTROBE: begin
          if (!out_q) begin
            out_d = 1'b1;                           // strobe lasts one pulse
          end
          if (lpend_q) begin
            ce_d    = cr_q;                         // load, no decrement
            lpend_d = 1'b0;
            run_d   = 1'b1;
            null_d  = 1'b0;
          end else if (gates_q) begin
            ce_d = dec1;
            if (run_q && ce_q == smic_pkg::SMIC_CNT_ONE) begin
              out_d = 1'b0;
              run_d = 1'b0;
            end
          end
        end
        smic_pkg::SMIC_M_HWSTROBE: begin
          if (!out_q) begin
            out_d = 1'b1;
          end
          if (trig_load) begin
            ce_d   = cr_q;                          // load on pulse after trigger
            run_d  = 1'b1;
            null_d = 1'b0;
          end else begin
            ce_d = dec1;
            if (run_q && ce_q == smic_pkg::SMIC_CNT_ONE) begin
              out_d = 1'b0;
              run_d = 1'b0;
            end
          end
        end
        default: begin
          ce_d = ce_q;
        end
      endcase
    end

    // gate low in modes 2 and 3 forces a low output high at once
    if (!gate_i && !out_q && (mode_q == smic_pkg::SMIC_M_RATE ||
        mode_q == smic_pkg::SMIC_M_SQUARE)) begin
      out_d   = 1'b1;
      extra_d = 1'b0;
    end

    // count byte writes
    if (wr_cnt) begin
      if (two_q && !lsbw_q) begin
        cr_d[7:0] = wdata_i;
        lsbw_d    = 1'b1;
        if (mode_q == smic_pkg::SMIC_M_TERMINAL) begin
          out_d = 1'b0;                             // halt and force low
        end
      end else if (two_q) begin
        cr_d[15:8] = wdata_i;
        lsbw_d     = 1'b0;
      end else begin
        cr_d = {8'h00, wdata_i};
      end
    end
    if (commit) begin
      null_d = 1'b1;
      crv_d  = 1'b1;
      case (mode_q)
        smic_pkg::SMIC_M_TERMINAL: begin
          out_d   = 1'b0;
          lpend_d = 1'b1;
        end
        smic_pkg::SMIC_M_SWSTROBE: begin
          lpend_d = 1'b1;                           // write starts sequence
        end
        smic_pkg::SMIC_M_RATE, smic_pkg::SMIC_M_SQUARE: begin
          lpend_d = ~run_q;                         // running period undisturbed
        end
        default: begin
          lpend_d = 1'b0;                           // armed, waits for trigger
        end
      endcase
    end

    // control word resets the channel
    if (wr_ctrl) begin
      bcd_d   = wdata_i[smic_pkg::SMIC_CW_BCD];
      two_d   = wdata_i[smic_pkg::SMIC_CW_TWO];
      mode_d  = (wdata_i[smic_pkg::SMIC_CW_MODE + 1 +: 2] == 2'b11) ?
                smic_pkg::smic_mode_t'({1'b0, wdata_i[smic_pkg::SMIC_CW_MODE +: 2]}) :
                smic_pkg::smic_mode_t'(wdata_i[smic_pkg::SMIC_CW_MODE +: 3]);
      out_d   = (mode_d != smic_pkg::SMIC_M_TERMINAL);  // mode 0 starts low
      null_d  = 1'b1;
      crv_d   = 1'b0;
      lpend_d = 1'b0;
      run_d   = 1'b0;
      lsbw_d  = 1'b0;
      extra_d = 1'b0;
    end

    // register reads, data in following cycle
    if (rd_i) begin
      case (addr_i)
        smic_pkg::SMIC_ADDR_CTRL:   rdata_d = {11'h000, two_q, mode_q, bcd_q};
        smic_pkg::SMIC_ADDR_COUNT:  rdata_d = cr_q;
        smic_pkg::SMIC_ADDR_STATUS: rdata_d = {8'h00, out_q, null_q, 1'b0, two_q, mode_q, bcd_q};
        default:                    rdata_d = ce_q;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      mode_q  <= smic_pkg::SMIC_M_TERMINAL;
      bcd_q   <= 1'b0;
      two_q   <= 1'b0;
      cr_q    <= smic_pkg::SMIC_RST_COUNT;
      ce_q    <= smic_pkg::SMIC_RST_COUNT;
      out_q   <= smic_pkg::SMIC_RST_OUT;
      null_q  <= 1'b0;
      crv_q   <= 1'b0;
      lpend_q <= 1'b0;
      run_q   <= 1'b0;
      lsbw_q  <= 1'b0;
      extra_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      mode_q  <= mode_d;
      bcd_q   <= bcd_d;
      two_q   <= two_d;
      cr_q    <= cr_d;
      ce_q    <= ce_d;
      out_q   <= out_d;
      null_q  <= null_d;
      crv_q   <= crv_d;
      lpend_q <= lpend_d;
      run_q   <= run_d;
      lsbw_q  <= lsbw_d;
      extra_q <= extra_d;
      rdata_q <= rdata_d;
    end
  end

  // outputs straight from flops
  assign out_o   = out_q;
  assign rdata_o = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_CTRL_INIT: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    wr_ctrl |=> (out_q == (mode_q != smic_pkg::SMIC_M_TERMINAL)) && !run_q && null_q)
    else $error("control write did not reset channel");

  AST_M0_FIRST_BYTE: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    wr_cnt && two_q && !lsbw_q && !wr_ctrl && mode_q == smic_pkg::SMIC_M_TERMINAL
    |=> !out_q && lsbw_q)
    else $error("first byte did not halt mode 0");

  AST_TRIG_CATCH: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    gate_rise |=> trig_q)
    else $error("gate edge not caught");

  AST_TRIG_CLEAR: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    cclk_rise && !gate_rise |=> !trig_q && (trigs_q == $past(trig_q)))
    else $error("trigger flop not sampled and cleared");

  AST_CE_ON_FALL: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !cclk_fall |=> $stable(ce_q))
    else $error("counting element moved off a falling edge");

  AST_GATE_LOW_HIGH: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !gate_i && !out_q && mode_q == smic_pkg::SMIC_M_RATE && !wr_ctrl |=> out_q)
    else $error("mode 2 gate low did not raise output");

  AST_SQ_GATE_LOW: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !gate_i && !out_q && mode_q == smic_pkg::SMIC_M_SQUARE && !wr_ctrl |=> out_q)
    else $error("mode 3 gate low did not raise output");

  AST_M1_TRIGGER: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    trig_load && mode_q == smic_pkg::SMIC_M_ONESHOT && !wr_i
    |=> !out_q && ce_q == $past(cr_q))
    else $error("mode 1 trigger did not start one-shot");

  AST_M0_ZERO: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    cclk_fall && mode_q == smic_pkg::SMIC_M_TERMINAL && run_q && gates_q && !lpend_q &&
    !lsbw_q && ce_q == smic_pkg::SMIC_CNT_ONE && !wr_i |=> out_q && ce_q == 16'h0000)
    else $error("mode 0 output not high at zero");

  AST_M2_RELOAD: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    cclk_fall && mode_q == smic_pkg::SMIC_M_RATE && run_q && gates_q && !lpend_q &&
    !trig_load && ce_q == smic_pkg::SMIC_CNT_ONE && !wr_i |=> out_q && ce_q == $past(cr_q))
    else $error("mode 2 did not reload after low pulse");

  AST_STROBE_ONE: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    mode_q == smic_pkg::SMIC_M_SWSTROBE && !out_q && !cclk_fall && !wr_i |=> !out_q)
    else $error("mode 4 strobe ended early");

  AST_STROBE_END: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    mode_q == smic_pkg::SMIC_M_SWSTROBE && !out_q && cclk_fall && !wr_ctrl |=> out_q)
    else $error("mode 4 strobe lasted past one pulse");

endmodule

`default_nettype wire

/* design/smic_pkg.sv */
// package for the six-mode interval counter channel: register map, fields, reset values
// assumes one 100 MHz system clock; counter clock and gate arrive synchronous to it
//
// Overview of operation
// - a counter clock pulse is rise then fall; a trigger is a gate rising edge
// - mode 0 output low after control write, high at zero until rewritten
// - mode 0 loads count on next pulse without decrement; output rises N+1 later
// - mode 0 two-byte: first byte halts counting, output low at once; second loads
// - mode 0 gate enables counting only; count still loads while gate is low
// - mode 1 armed by count write; trigger loads and drives output low N pulses
// - mode 1 new count waits for a retrigger before it takes effect
// - mode 2 output low one pulse at count 1, then reload, period N
// - mode 2 gate low stops counting, forces output high; trigger reloads
// - mode 2 new count takes effect on trigger or at period end
// - initial count 0 counts as 65536 binary or 10000 decimal
// - mode 3 square wave, high first half, period N pulses
// - mode 3 even count loads N, steps by two, toggles and reloads on expiry
// - mode 3 odd count loads N-1, high (N+1)/2 and low (N-1)/2 pulses
// - mode 3 gate low stops counting, forces output high; trigger reloads
// - mode 3 new count takes effect on trigger or at half-cycle end
// - mode 4 count write starts sequence, strobe low one pulse N+1 later
// - mode 4 two-byte: first byte leaves counting alone, second byte loads
// - mode 5 trigger loads on next pulse, strobe N+1 pulses after trigger
// - mode 5 new count waits for a trigger before it takes effect
// - counts load and decrement on the falling edge of the counter clock
// - gate rise is caught in a flop, sampled at next counter rise, then cleared
// - control word write resets control logic and sets output's initial state
// - modes 0,1,4,5 wrap to FFFF or 9999; modes 2,3 reload
`default_nettype none

package smic_pkg;

  // counting modes, in control word order
  typedef enum logic [2:0] {
    SMIC_M_TERMINAL,
    SMIC_M_ONESHOT,
    SMIC_M_RATE,
    SMIC_M_SQUARE,
    SMIC_M_SWSTROBE,
    SMIC_M_HWSTROBE
  } smic_mode_t;

  // register offsets
  localparam logic [1:0] SMIC_ADDR_CTRL   = 2'h0;
  localparam logic [1:0] SMIC_ADDR_COUNT  = 2'h1;
  localparam logic [1:0] SMIC_ADDR_STATUS = 2'h2;
  localparam logic [1:0] SMIC_ADDR_ELEM   = 2'h3;

  // control word fields
  localparam int SMIC_CW_BCD  = 0;
  localparam int SMIC_CW_MODE = 1;
  localparam int SMIC_CW_TWO  = 4;

  // status field positions
  localparam int SMIC_ST_BCD  = 0;
  localparam int SMIC_ST_MODE = 1;
  localparam int SMIC_ST_TWO  = 4;
  localparam int SMIC_ST_NULL = 6;
  localparam int SMIC_ST_OUT  = 7;

  // reset values and count landmarks
  localparam logic [15:0] SMIC_RST_COUNT = 16'h0000;
  localparam logic        SMIC_RST_OUT   = 1'b1;
  localparam logic [15:0] SMIC_CNT_ONE   = 16'h0001;
  localparam logic [15:0] SMIC_CNT_TWO   = 16'h0002;
  localparam logic [15:0] SMIC_CNT_ZERO  = 16'h0000;

  // decrement by one, binary or four-digit decimal, wrapping at zero
  function automatic logic [15:0] smic_dec(input logic [15:0] v, input logic bcd);
    logic [15:0] r;
    logic        borrow;
    r      = v;
    borrow = 1'b1;
    if (!bcd) begin
      r = v - 16'h0001;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (borrow) begin
          if (r[i*4 +: 4] == 4'h0) begin
            r[i*4 +: 4] = 4'h9;
          end else begin
            r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
            borrow      = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

endpackage

`default_nettype wire
